/* File: design/pt_pkg.sv */
package pt_pkg;
  localparam logic [3:0] CMD_MRD = 4'h6;
  localparam logic [3:0] CMD_MWR = 4'h7;
  localparam logic [3:0] CMD_CRD = 4'ha;
  localparam logic [3:0] CMD_CWR = 4'hb;
  localparam logic [3:0] CMD_MRM = 4'hc;
  localparam logic [3:0] CMD_MRL = 4'he;
  localparam logic [3:0] CMD_MWI = 4'hf;

  localparam logic [1:0] CFG_TYPE0 = 2'h0;
  localparam int BAR0_LSB = 17;
  localparam int BAR1_LSB = 12;
  localparam logic [11:0] IF_FIRST = 12'h800;
  localparam logic [11:0] IF_LAST  = 12'h81c;
  localparam logic [11:0] REG_LAST = 12'h0fc;
  localparam logic [2:0] IF_STATUS_IDX = 3'h0;
  localparam int FIFO_NE_BIT = 30;

  localparam int FIFO_AW = 5;
  localparam int IDX_W = 15;
  localparam int FIFO_W = 1 + IDX_W + 4 + 32;

  typedef enum logic [1:0] {
    PT_IDLE = 2'h0,
    PT_WAIT = 2'h1,
    PT_DATA = 2'h3,
    PT_TURN = 2'h2
  } pt_st_e;

  typedef enum logic [1:0] {
    PT_C_IDLE = 2'h0,
    PT_C_LO   = 2'h1,
    PT_C_HI   = 2'h3
  } pt_cst_e;

  typedef enum logic [1:0] {
    PT_SP_CFG = 2'h0,
    PT_SP_IF  = 2'h1,
    PT_SP_MEM = 2'h2,
    PT_SP_REG = 2'h3
  } pt_sp_e;

  typedef struct packed {
    pt_st_e st; pt_cst_e cst; pt_sp_e sp;
    logic frame_q, rd, devsel_n, trdy_n, stop_n, targ_oe, ad_oe, par, par_oe, cfg_wr, if_wr;
    logic [31:0] ad_out; logic [IDX_W-1:0] aidx; logic [3:0] cmd;
    logic [31:0] wr_data; logic [3:0] wr_be;
    logic [FIFO_AW:0] wp, rp;
    logic drr_pend, drr_rdy, d_reg; logic [IDX_W-1:0] d_idx; logic [3:0] d_be, d_cmd;
    logic [31:0] d_data;
    logic j_rd, j_reg; logic [IDX_W-1:0] j_idx; logic [3:0] j_be; logic [31:0] j_data;
    logic core_req, core_we, core_reg; logic [15:0] core_addr, core_wdata; logic [1:0] core_be;
  } pt_state_s;
endpackage

/* File: design/pt_target.sv */
`timescale 1ns/10ps
// Function
// R1: Claim configuration cycles only when address bits 1:0 are zero (type zero).
// R2: Configuration reads drive the full 32-bit word regardless of byte enables.
// R3: Configuration writes honour byte enables; empty burst phase skips write, advances address.
// R4: Interface register window reads complete at once with data, no delayed read.
// R5: Core-space read with FIFO empty and nothing outstanding queues delayed read, retries.
// R6: Core-space read with FIFO data or outstanding read retries without queueing.
// R7: Repeats retry until fetched data arrives, then complete with disconnect with data.
// R8: Initiator repeats the identical read (address, command, enables) until completed.
// R9: Core memory reads accept any enables; single-byte lane still drives whole half.
// R10: Core register read enabling one byte within a half ends with target abort.
// R11: Register read of upper half only or no bytes returns zeros quickly.
// R12: Single-half fetch takes one core access, lower register or memory word.
// R13: Full Dword memory read uses two 16-bit core accesses.
// R14: Core contention stretches the fetch; core ack timing absorbs it.
// R15: Accelerated host access lives in core configuration register six bit 14.
// R16: Interface register 800h bit 30 shows write FIFO not empty, read directly.
// R17: Host software should poll FIFO-not-empty before reading core space.
// R18: Any target-terminated transaction ends within 5 bus clocks of its start.
// R19: Core-space writes enter the write FIFO; interface register writes go direct.
// R20: Core memory write with one byte enabled within a half is target aborted.
// R21: Register writes abort on single bytes; only lower half reaches 16-bit registers.
// R22: Memory write and invalidate behaves exactly as memory write.
// R23: Initiator retry limits should exceed 84 or be disabled.
// R24: Basic transaction takes 3 clocks after command phase; single write is 4.
// R25: FIFO drains in order, each Dword split into lower and upper core accesses; halves with no enables and register upper halves are skipped.
module pt_target
  import pt_pkg::*;
(
  input  wire logic        clk,          // Bus clock
  input  wire logic        sys_rst,      // Synchronous reset
  input  wire logic        ce,           // Clock enable
  input  wire logic        frame_n,      // Cycle frame
  input  wire logic        irdy_n,       // Initiator ready
  input  wire logic        idsel,        // Configuration select
  input  wire logic [3:0]  cbe_n,        // Command / byte enables
  input  wire logic [31:0] ad_in,        // Address/data in
  output logic      [31:0] ad_out,       // Address/data out
  output logic             ad_oe,        // Address/data drive enable
  output logic             par_out,      // Parity out
  output logic             par_oe,       // Parity drive enable
  output logic             devsel_n,     // Device select
  output logic             trdy_n,       // Target ready
  output logic             stop_n,       // Stop
  output logic             targ_oe,      // Enable for devsel/trdy/stop
  input  wire logic        mem_en,       // Memory space enable
  input  wire logic [14:0] bar0_base,    // Core memory window base bits 31:17
  input  wire logic [19:0] bar1_base,    // Register window base bits 31:12
  output logic      [5:0]  cfg_idx,      // Configuration dword index
  input  wire logic [31:0] cfg_rdata,    // Configuration read data
  output logic             cfg_wr,       // Configuration write strobe
  output logic      [2:0]  if_idx,       // Interface register index
  input  wire logic [31:0] if_rdata,     // Interface register read data
  output logic             if_wr,        // Interface register write strobe
  output logic      [31:0] wr_data,      // Write data for cfg/if strobes
  output logic      [3:0]  wr_be,        // Byte enables for cfg/if strobes
  output logic             core_req,     // Core access request
  output logic             core_we,      // Core access is a write
  output logic             core_reg,     // Core register window, else memory
  output logic      [15:0] core_addr,    // Core 16-bit word address
  output logic      [1:0]  core_be,      // Core byte enables
  output logic      [15:0] core_wdata,   // Core write data
  input  wire logic        core_ack,     // Core access done
  input  wire logic [15:0] core_rdata    // Core read data
);
  pt_state_s s;
  pt_state_s n;
  logic [FIFO_W-1:0] fifo_mem [2**FIFO_AW];
  logic [FIFO_W-1:0] entry;
  logic push;
  logic emp;
  logic full;
  logic [3:0] be;
  logic sgl;
  logic done;
  logic xfer;
  logic go;
  logic half;
  logic [3:0] cmd;
  logic is_mem;
  logic is_rd;

  assign ad_out     = s.ad_out;
  assign ad_oe      = s.ad_oe;
  assign par_out    = s.par;
  assign par_oe     = s.par_oe;
  assign devsel_n   = s.devsel_n;
  assign trdy_n     = s.trdy_n;
  assign stop_n     = s.stop_n;
  assign targ_oe    = s.targ_oe;
  assign cfg_idx    = s.aidx[5:0];
  assign cfg_wr     = s.cfg_wr;
  assign if_idx     = s.aidx[2:0];
  assign if_wr      = s.if_wr;
  assign wr_data    = s.wr_data;
  assign wr_be      = s.wr_be;
  assign core_req   = s.core_req;
  assign core_we    = s.core_we;
  assign core_reg   = s.core_reg;
  assign core_addr  = s.core_addr;
  assign core_be    = s.core_be;
  assign core_wdata = s.core_wdata;

  always_comb begin
    n = s;
    push = 1'b0;
    go = 1'b0;
    half = 1'b0;
    emp = (s.wp == s.rp);
    full = (s.wp[FIFO_AW-1:0] == s.rp[FIFO_AW-1:0]) && (s.wp[FIFO_AW] != s.rp[FIFO_AW]);
    be = ~cbe_n;
    sgl = (be[1] ^ be[0]) | (be[3] ^ be[2]);
    cmd = cbe_n;
    // Write-and-invalidate decodes as a plain write
    is_mem = (cmd == CMD_MRD) || (cmd == CMD_MWR) || (cmd == CMD_MRM) || (cmd == CMD_MRL) ||
             (cmd == CMD_MWI); // R22
    is_rd = (cmd == CMD_MRD) || (cmd == CMD_MRM) || (cmd == CMD_MRL) || (cmd == CMD_CRD);
    done = ~irdy_n & (~s.trdy_n | ~s.stop_n);
    xfer = ~irdy_n & ~s.trdy_n;
    entry = {s.sp == PT_SP_REG, s.aidx, be, ad_in};
    n.frame_q = frame_n;
    n.cfg_wr = 1'b0;
    n.if_wr = 1'b0;
    n.par = ^{s.ad_out, cbe_n};
    n.par_oe = s.ad_oe;

    case (s.st)
      PT_IDLE: begin
        if (~frame_n && s.frame_q) begin
          n.cmd = cmd;
          n.rd = is_rd;
          n.aidx = ad_in[16:2];
          if ((cmd == CMD_CRD || cmd == CMD_CWR) && idsel && ad_in[1:0] == CFG_TYPE0) begin // R1
            n.sp = PT_SP_CFG;
            n.st = PT_WAIT;
          end else if (is_mem && mem_en && ad_in[31:BAR0_LSB] == bar0_base) begin
            n.sp = PT_SP_MEM;
            n.st = PT_WAIT;
          end else if (is_mem && mem_en && ad_in[31:BAR1_LSB] == bar1_base) begin
            if (ad_in[11:0] >= IF_FIRST && ad_in[11:0] <= IF_LAST) begin
              n.sp = PT_SP_IF;
              n.st = PT_WAIT;
            end else if (ad_in[11:0] <= REG_LAST) begin
              n.sp = PT_SP_REG;
              n.st = PT_WAIT;
            end
          end
          if (n.st == PT_WAIT) begin
            // Claim on the clock after the command phase
            n.devsel_n = 1'b0; // R24
            n.targ_oe = 1'b1;
            n.ad_oe = is_rd;
          end
        end
      end
      PT_WAIT: begin
        // Decide once byte enables are valid; answer one clock later, well inside five
        if (~irdy_n) begin // R18
          n.st = PT_DATA;
          case (s.sp)
            PT_SP_CFG: begin
              if (s.rd) begin
                n.ad_out = cfg_rdata; // R2
                n.stop_n = 1'b0;
              end
              n.trdy_n = 1'b0;
            end
            PT_SP_IF: begin
              if (s.rd) begin
                n.ad_out = if_rdata; // R4
                if (s.aidx[2:0] == IF_STATUS_IDX) begin
                  n.ad_out[FIFO_NE_BIT] = ~emp; // R16
                end
                n.stop_n = 1'b0;
              end
              n.trdy_n = 1'b0;
            end
            default: begin
              if (s.rd) begin
                if (s.sp == PT_SP_REG && sgl) begin
                  n.devsel_n = 1'b1; // R10
                  n.stop_n = 1'b0;
                end else if (be == 4'h0 || (s.sp == PT_SP_REG && be[1:0] == 2'h0)) begin
                  n.ad_out = '0; // R11
                  n.trdy_n = 1'b0;
                  n.stop_n = 1'b0;
                end else if (s.drr_rdy && s.aidx == s.d_idx && be == s.d_be && s.cmd == s.d_cmd &&
                             (s.sp == PT_SP_REG) == s.d_reg) begin // R8
                  n.ad_out = s.d_data; // R7
                  n.trdy_n = 1'b0;
                  n.stop_n = 1'b0;
                  n.drr_pend = 1'b0;
                  n.drr_rdy = 1'b0;
                end else if (!emp || s.drr_pend) begin
                  n.stop_n = 1'b0; // R6
                end else begin
                  n.stop_n = 1'b0; // R5
                  n.drr_pend = 1'b1;
                  n.d_reg = (s.sp == PT_SP_REG);
                  n.d_idx = s.aidx;
                  n.d_be = be;
                  n.d_cmd = s.cmd;
                end
              end else if (sgl) begin
                n.devsel_n = 1'b1; // R20 R21
                n.stop_n = 1'b0;
              end else if (full) begin
                // A full FIFO ends the burst; the initiator comes back later
                n.stop_n = 1'b0;
              end else begin
                n.trdy_n = 1'b0;
              end
            end
          endcase
        end
      end
      PT_DATA: begin
        if (xfer && !s.rd) begin
          n.wr_data = ad_in;
          n.wr_be = be;
          case (s.sp)
            PT_SP_CFG: n.cfg_wr = (be != 4'h0); // R3
            PT_SP_IF:  n.if_wr = 1'b1; // R19
            default:   push = 1'b1; // R19
          endcase
        end
        if (xfer) begin
          n.aidx = s.aidx + 1'b1; // R3
        end
        if (done) begin
          n.trdy_n = 1'b1;
          n.ad_oe = 1'b0;
          if (frame_n) begin
            n.st = PT_TURN;
            n.devsel_n = 1'b1;
            n.stop_n = 1'b1;
          end else if (s.stop_n) begin
            n.st = PT_WAIT;
          end
        end
      end
      default: begin
        n.targ_oe = 1'b0;
        n.st = PT_IDLE;
      end
    endcase

    if (push) begin
      n.wp = s.wp + 1'b1;
    end

    // Core side: writes drain in order, a queued read waits for an empty FIFO
    case (s.cst)
      PT_C_IDLE: begin
        if (!emp) begin
          {n.j_reg, n.j_idx, n.j_be, n.j_data} = fifo_mem[s.rp[FIFO_AW-1:0]]; // R25
          n.j_rd = 1'b0;
          n.rp = s.rp + 1'b1;
        end else if (s.drr_pend && !s.drr_rdy) begin
          n.j_reg = s.d_reg;
          n.j_idx = s.d_idx;
          n.j_be = s.d_be;
          n.j_data = '0;
          n.j_rd = 1'b1;
        end
        if (!emp || (s.drr_pend && !s.drr_rdy)) begin
          if (n.j_be[1:0] != 2'h0) begin
            go = 1'b1; // R12
            n.cst = PT_C_LO;
          end else if (!n.j_reg && n.j_be[3:2] != 2'h0) begin
            go = 1'b1;
            half = 1'b1;
            n.cst = PT_C_HI;
          end
        end
      end
      PT_C_LO: begin
        // Ack may be late while the core holds its RAM; the wait is open-ended here
        if (core_ack) begin // R14 R15
          if (s.j_rd) begin
            n.j_data[15:0] = core_rdata; // R9
          end
          if (!s.j_reg && s.j_be[3:2] != 2'h0) begin
            go = 1'b1; // R13
            half = 1'b1;
            n.cst = PT_C_HI;
          end else begin
            n.cst = PT_C_IDLE; // R21
          end
        end
      end
      default: begin
        if (core_ack) begin
          if (s.j_rd) begin
            n.j_data[31:16] = core_rdata;
          end
          n.cst = PT_C_IDLE;
        end
      end
    endcase

    if (go) begin
      n.core_req = 1'b1;
      n.core_we = ~n.j_rd;
      n.core_reg = n.j_reg;
      n.core_addr = {n.j_idx, half};
      n.core_be = half ? n.j_be[3:2] : n.j_be[1:0];
      n.core_wdata = half ? n.j_data[31:16] : n.j_data[15:0];
    end else if (s.cst != PT_C_IDLE && n.cst == PT_C_IDLE) begin
      n.core_req = 1'b0;
      if (s.j_rd) begin
        n.drr_rdy = 1'b1;
        n.d_data = n.j_data;
      end
    end

    if (sys_rst) begin
      n = '0;
      n.frame_q = 1'b1;
      n.devsel_n = 1'b1;
      n.trdy_n = 1'b1;
      n.stop_n = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (ce || sys_rst) begin
      s <= n;
    end
  end

  // Storage has no reset; pointers alone define what is valid
  always_ff @(posedge clk) begin
    if (ce && push && !sys_rst) begin
      fifo_mem[s.wp[FIFO_AW-1:0]] <= entry;
    end
  end
endmodule

/* File: tb/pt_core_model.sv */
`timescale 1ns/10ps
module pt_core_model (
  input  wire logic        clk,        // Core clock, shared with the bus here
  input  wire logic        sys_rst,    // Synchronous reset
  input  wire logic        slow,       // Shared RAM contended by the core
  input  wire logic        core_req,   // Access request
  input  wire logic [15:0] core_addr,  // Word address
  output logic             core_ack,   // One-cycle done pulse
  output logic      [15:0] core_rdata  // Read data, valid with core_ack
);
  logic [5:0] cnt_r;

  always_ff @(posedge clk) begin
    if (sys_rst || !core_req || core_ack) begin
      cnt_r    <= 6'h00;
      core_ack <= 1'b0;
    end else begin
      cnt_r    <= cnt_r + 6'h01;
      // Contention stretches every access, as the busy core would
      core_ack <= cnt_r == (slow ? 6'h13 : 6'h03);
    end
    // Outside a pending request the data lines invert every cycle, so the last word returns every other cycle
    core_rdata <= (core_req && !core_ack) ? core_addr ^ 16'h5a00 : ~core_rdata;
  end
endmodule

/* File: tb/pt_target_chk.sv */
`timescale 1ns/10ps
module pt_target_chk (
  input wire logic        clk,       // Bus clock
  input wire logic        sys_rst,   // Synchronous reset
  input wire logic        frame_n,   // Cycle frame
  input wire logic        irdy_n,    // Initiator ready
  input wire logic        devsel_n,  // Device select
  input wire logic        trdy_n,    // Target ready
  input wire logic        stop_n,    // Stop
  input wire logic        targ_oe,   // Target control enable
  input wire logic        cfg_wr,    // Config write strobe
  input wire logic        core_req,  // Core request
  input wire logic        core_ack,  // Core done
  input wire logic [15:0] core_addr  // Core word address
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_addr;
    $fell(frame_n);
  endsequence
  sequence s_claim;
    s_addr ##1 !devsel_n;
  endsequence

  claim_delay_a: assert property ($fell(devsel_n) |-> $past(!frame_n) && $past(frame_n, 2))
    else $error("device select not one cycle after address phase");
  term_bound_a: assert property (s_claim |-> ##[1:3] (!trdy_n || !stop_n))
    else $error("transaction not ended in time");
  stop_hold_a: assert property (!stop_n && !(frame_n && !irdy_n) |=> !stop_n)
    else $error("stop released early");
  disc_single_a: assert property (!trdy_n && !stop_n |=> trdy_n && stop_n)
    else $error("disconnect with data longer than one phase");
  abort_form_a: assert property (targ_oe && devsel_n && !stop_n |->
                                 trdy_n && ($past(!devsel_n) || $past(!stop_n)))
    else $error("malformed target abort");
  turn_idle_a: assert property ($fell(targ_oe) |-> $past(devsel_n && trdy_n && stop_n))
    else $error("control released without idle turn cycle");
  core_hold_a: assert property (core_req && !core_ack |=> core_req && $stable(core_addr))
    else $error("core request dropped or changed before ack");
  cfg_pulse_a: assert property (cfg_wr |=> !cfg_wr)
    else $error("config write strobe longer than one cycle");
endmodule

bind pt_target pt_target_chk u_chk (.clk(clk), .sys_rst(sys_rst), .frame_n(frame_n), .irdy_n(irdy_n),
  .devsel_n(devsel_n), .trdy_n(trdy_n), .stop_n(stop_n), .targ_oe(targ_oe), .cfg_wr(cfg_wr),
  .core_req(core_req), .core_ack(core_ack), .core_addr(core_addr));

/* File: tb/pt_target_tb.sv */
`timescale 1ns/10ps
module pt_target_tb;
  import pt_pkg::*;
  localparam logic [31:0] MB = 32'h0002_0000;
  localparam logic [31:0] RB = 32'h0004_0000;
  logic        clk, sys_rst, frame_n, irdy_n, idsel, slow, ad_oe, par_out, par_oe;
  logic        devsel_n, trdy_n, stop_n, targ_oe, cfg_wr, if_wr, core_req, core_we, core_reg, core_ack;
  logic [3:0]  cbe_n, wr_be, sb;
  logic [31:0] ad_in, ad_out, wr_data, sd, rdv;
  logic [31:0] wlog [8];
  logic [5:0]  cfg_idx;
  logic [2:0]  if_idx;
  logic [1:0]  core_be, tm;
  logic [15:0] core_addr, core_wdata, core_rdata;
  int          bad_count, check_count, cyc, wn, lat, tries;
  wire logic [31:0] cfg_rdata = 32'hc0de_0000 | 32'(cfg_idx);
  wire logic [31:0] if_rdata = 32'h4000_1230 | 32'(if_idx);

  pt_target dut (.clk(clk), .sys_rst(sys_rst), .ce(1'b1), .frame_n(frame_n), .irdy_n(irdy_n),
    .idsel(idsel), .cbe_n(cbe_n), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe), .par_out(par_out),
    .par_oe(par_oe), .devsel_n(devsel_n), .trdy_n(trdy_n), .stop_n(stop_n), .targ_oe(targ_oe),
    .mem_en(1'b1), .bar0_base(15'h0001), .bar1_base(20'h00040), .cfg_idx(cfg_idx),
    .cfg_rdata(cfg_rdata), .cfg_wr(cfg_wr), .if_idx(if_idx), .if_rdata(if_rdata), .if_wr(if_wr),
    .wr_data(wr_data), .wr_be(wr_be), .core_req(core_req), .core_we(core_we), .core_reg(core_reg),
    .core_addr(core_addr), .core_be(core_be), .core_wdata(core_wdata), .core_ack(core_ack),
    .core_rdata(core_rdata));
  pt_core_model u_core (.clk(clk), .sys_rst(sys_rst), .slow(slow), .core_req(core_req),
    .core_addr(core_addr), .core_ack(core_ack), .core_rdata(core_rdata));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (core_ack && core_we) begin
      wlog[wn[2:0]] = {core_addr, core_wdata};
      wn++;
    end
    if (cfg_wr || if_wr) begin
      sd = wr_data;
      sb = wr_be;
    end
    if (cyc == 5000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH at %0t got %h expected %h", $time, g, e);
    end
  endtask

  // Single data phase; the initiator drops frame with irdy so every access is one phase
  // lat counts clocks after the address phase up to the one showing the answer; turnaround is the next
  task automatic bus(input logic [3:0] c, input logic [31:0] a, input logic [3:0] be,
                     input logic [31:0] d, input logic sel);
    @(posedge clk);
    frame_n <= 1'b0;
    cbe_n   <= c;
    ad_in   <= a;
    idsel   <= sel;
    @(posedge clk);
    frame_n <= 1'b1;
    irdy_n  <= 1'b0;
    cbe_n   <= ~be;
    ad_in   <= d;
    tm = 2'h3;
    lat = 0;
    while (tm == 2'h3 && lat < 6) begin
      @(negedge clk);
      lat++;
      if (trdy_n === 1'b0) begin
        tm  = 2'h0;
        rdv = ad_out;
      end else if (stop_n === 1'b0) begin
        tm = devsel_n ? 2'h2 : 2'h1;
      end
    end
    @(posedge clk);
    irdy_n <= 1'b1;
    idsel  <= 1'b0;
    ad_in  <= ~d;
    repeat (2) @(posedge clk);
  endtask

  task automatic rd_core(input logic [3:0] c, input logic [31:0] a, input logic [3:0] be);
    tries = 0;
    tm = 2'h1;
    // Retry ceiling kept above the worst drain behind a full FIFO
    while (tm == 2'h1 && tries < 90) begin
      bus(c, a, be, 32'h0, 1'b0);
      tries++;
    end
    chk(40'(tm), 40'h0);
  endtask

  task automatic t_cfg();
    bus(CMD_CWR, 32'h10, 4'h5, 32'h1122_3344, 1'b1);
    chk({sb, sd}, 40'h5_1122_3344);
    bus(CMD_CRD, 32'h14, 4'h0, 32'h0, 1'b1);
    chk({tm, rdv}, 40'hc0de_0005);
    bus(CMD_CRD, 32'h15, 4'hf, 32'h0, 1'b1);
    chk(40'(tm), 40'h3);
    $display("test cfg done");
  endtask

  task automatic t_if();
    bus(CMD_MRD, RB + 32'h800, 4'hf, 32'h0, 1'b0);
    chk({tm, rdv}, 40'h0000_1230);
    bus(CMD_MWR, RB + 32'h818, 4'hf, 32'h0bad_f00d, 1'b0);
    chk({sb, sd}, 40'hf_0bad_f00d);
    chk(40'(lat), 40'h2);
    $display("test if done");
  endtask

  task automatic t_wr();
    int w;
    slow <= 1'b1;
    bus(CMD_MWR, MB + 32'h20, 4'hf, 32'hbeef_cafe, 1'b0);
    chk(40'(tm), 40'h0);
    bus(CMD_MWI, MB + 32'h24, 4'hc, 32'h1357_0000, 1'b0);
    chk(40'(tm), 40'h0);
    bus(CMD_MWR, RB + 32'h8, 4'hc, 32'h2468_0000, 1'b0);
    chk(40'(tm), 40'h0);
    bus(CMD_MWR, MB + 32'h28, 4'h1, 32'h0, 1'b0);
    chk(40'(tm), 40'h2);
    bus(CMD_MRD, RB + 32'h800, 4'hf, 32'h0, 1'b0);
    chk(40'(rdv[30]), 40'h1);
    bus(CMD_MRD, MB + 32'h20, 4'hf, 32'h0, 1'b0);
    chk(40'(tm), 40'h1);
    w = 0;
    while (wn < 3 && w < 400) begin
      @(posedge clk);
      w++;
    end
    // Give the upper-half-only register write time to show up if it were not dropped
    repeat (40) @(posedge clk);
    chk({wlog[0], 8'h0}, 40'h0010_cafe_00);
    chk({wlog[1], 8'h0}, 40'h0011_beef_00);
    chk({wlog[2], 8'(wn)}, 40'h0013_1357_03);
    $display("test wr done");
  endtask

  task automatic t_rd();
    slow <= 1'b0;
    tries = 0;
    rdv = 32'h4000_0000;
    while (rdv[FIFO_NE_BIT] && tries < 20) begin
      bus(CMD_MRD, RB + 32'h800, 4'hf, 32'h0, 1'b0);
      tries++;
    end
    chk(40'(rdv[FIFO_NE_BIT]), 40'h0);
    rd_core(CMD_MRD, MB + 32'h20, 4'hf);
    chk({rdv, 8'(tries > 1)}, 40'h5a11_5a10_01);
    rd_core(CMD_MRL, MB + 32'h30, 4'h2);
    chk(40'(rdv[15:0]), 40'h5a18);
    rd_core(CMD_MRD, RB + 32'h8, 4'hf);
    chk(40'(rdv), 40'h0000_5a04);
    bus(CMD_MRD, RB + 32'h10, 4'h1, 32'h0, 1'b0);
    chk(40'(tm), 40'h2);
    bus(CMD_MRD, RB + 32'h10, 4'hc, 32'h0, 1'b0);
    chk({tm, rdv, 6'(lat)}, 40'h02);
    $display("test rd done");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    sys_rst = 1'b1;
    frame_n = 1'b1;
    irdy_n  = 1'b1;
    idsel   = 1'b0;
    slow    = 1'b0;
    cbe_n   = 4'h0;
    ad_in   = 32'h0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    t_cfg();
    t_if();
    t_wr();
    t_rd();
    finish_test();
  end
endmodule
